// *** hdl/module_sideband_defines.svh ***
`ifndef MODULE_SIDEBAND_DEFINES_SVH
`define MODULE_SIDEBAND_DEFINES_SVH
// lower page special bytes
`define OFF_FLAGS 8'h08
`define OFF_CTRL 8'h1A
`define OFF_BANK 8'h7E
`define OFF_PAGE 8'h7F
`define CTRL_HP_BIT 4
// upper page codes
`define PAGE_00 8'h00
`define PAGE_03 8'h03
`define PAGE_10 8'h10
`define PAGE_11 8'h11
// reset values
`define RST_BYTE 8'h00
// timing
`define CLK_PERIOD_NS 5
`define T_RESET_INIT_NS 10000
`define RESET_INIT_CYCLES ((`T_RESET_INIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MGMT_INIT_CYCLES 16
`endif

// *** hdl/sideband_pkg.sv ***
package sideband_pkg;
  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_ADDR      = 4'b0001,
    ST_ADDR_ACK  = 4'b0010,
    ST_OFFS      = 4'b0011,
    ST_OFFS_ACK  = 4'b0100,
    ST_WDATA     = 4'b0101,
    ST_WDATA_ACK = 4'b0110,
    ST_RDATA     = 4'b0111,
    ST_RACK      = 4'b1000
  } serial_state_e;
  typedef struct packed {
    logic init;
    logic rst_n;
    logic sel_n;
    logic sda;
    logic scl;
  } pins_s;
endpackage

// *** hdl/module_sideband_and_paged_map.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "module_sideband_defines.svh"
module module_sideband_and_paged_map #(
  parameter logic [6:0] DEV_ADDR     = 7'h50,
  parameter logic [7:0] VENDOR_ID    = 8'h5A, // arbitrary value
  parameter int         RESET_CYCLES = `RESET_INIT_CYCLES,
  parameter int         INIT_CYCLES  = `MGMT_INIT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       module_select_n,
  input  wire logic       module_reset_n,
  input  wire logic       init_control_select,
  input  wire logic [7:0] flag_event,
  output logic            interrupt_n,
  output logic            module_present_n,
  output logic            high_power_mode,
  output logic            mgmt_ready
);
  sideband_pkg::pins_s raw, s1_reg, s2_reg, s3_reg, pin_reg, pin_next, prev_reg;
  sideband_pkg::serial_state_e st_reg, st_next;
  logic [15:0] rcnt_reg, rcnt_next, icnt_reg, icnt_next;
  logic [7:0]  flags_reg, flags_next, rd_clear, rd_data;
  logic [7:0]  ctrl_reg, ctrl_next, page_reg, page_next, bank_reg, bank_next;
  logic [7:0]  sh_reg, sh_next, ptr_reg, ptr_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic        oe_reg, oe_next, rw_reg, rw_next, ack_reg, ack_next;
  logic        hp_reg, hp_next, intn_reg, hold, lr, wr_en, do_load, map_hit;
  logic        scl_rise, scl_fall, start, stop;
  logic [8:0]  map_idx;
  logic [7:0]  mem [0:383];

  // pins pass three flops; a level counts once the last two agree
  assign raw      = {init_control_select, module_reset_n, module_select_n, sda_in, scl};
  assign pin_next = ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & pin_reg);
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg   <= 5'h1F;
      s2_reg   <= 5'h1F;
      s3_reg   <= 5'h1F;
      pin_reg  <= 5'h1F;
      prev_reg <= 5'h1F;
    end else begin
      s1_reg   <= raw;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      pin_reg  <= pin_next;
      prev_reg <= pin_reg;
    end
  end

  // bus conditions from the filtered levels
  assign scl_rise = pin_reg.scl & ~prev_reg.scl;
  assign scl_fall = ~pin_reg.scl & prev_reg.scl;
  assign start    = pin_reg.scl & prev_reg.scl & prev_reg.sda & ~pin_reg.sda;
  assign stop     = pin_reg.scl & prev_reg.scl & ~prev_reg.sda & pin_reg.sda;

  // reset pin must stay low for the full pulse length; short glitches are ignored
  assign rcnt_next = pin_reg.rst_n ? 16'h0000 :
                     (hold ? rcnt_reg : rcnt_reg + 16'h0001);
  assign hold      = (rcnt_reg == 16'(RESET_CYCLES));
  assign lr        = rst | hold;
  assign icnt_next = mgmt_ready ? icnt_reg : icnt_reg + 16'h0001;
  assign mgmt_ready = (icnt_reg == 16'(INIT_CYCLES));

  // power mode and sticky flags; a new event beats a read clear
  assign hp_next    = mgmt_ready & (~pin_reg.init | ctrl_reg[`CTRL_HP_BIT]);
  assign flags_next = (flags_reg & ~rd_clear) | flag_event |
                      {7'h00, hp_next ^ hp_reg};
  always_ff @(posedge clk) begin
    if (rst) begin
      rcnt_reg <= 16'h0000;
    end else begin
      rcnt_reg <= rcnt_next;
    end
    if (lr) begin
      icnt_reg  <= 16'h0000;
      hp_reg    <= 1'b0;
      flags_reg <= `RST_BYTE;
      intn_reg  <= 1'b1;
    end else begin
      icnt_reg  <= icnt_next;
      hp_reg    <= hp_next;
      flags_reg <= flags_next;
      intn_reg  <= ~|flags_next;
    end
  end
  assign high_power_mode  = hp_reg;
  assign interrupt_n      = intn_reg;
  assign module_present_n = 1'b0;
  assign sda_out          = 1'b0; // open drain: only ever pulls low
  assign sda_oe           = oe_reg;

  // upper half goes to the selected page; banked pages exist only in bank 0
  always_comb begin
    map_hit = 1'b0;
    map_idx = {2'b00, ptr_reg[6:0]};
    if (ptr_reg[7]) begin
      if (page_reg == `PAGE_03) begin
        map_hit = 1'b1;
      end else if (bank_reg == 8'h00 && page_reg == `PAGE_10) begin
        map_hit = 1'b1;
        map_idx = {2'b01, ptr_reg[6:0]};
      end else if (bank_reg == 8'h00 && page_reg == `PAGE_11) begin
        map_hit = 1'b1;
        map_idx = {2'b10, ptr_reg[6:0]};
      end
    end
  end

  // read mux; pages 00 to 02 are fixed content, everything unused reads zero
  always_comb begin
    rd_data = 8'h00;
    if (!ptr_reg[7]) begin
      unique case (ptr_reg)
        `OFF_FLAGS: rd_data = flags_reg;
        `OFF_CTRL:  rd_data = ctrl_reg;
        `OFF_BANK:  rd_data = bank_reg;
        `OFF_PAGE:  rd_data = page_reg;
        default:    rd_data = 8'h00;
      endcase
    end else if (map_hit) begin
      rd_data = mem[map_idx];
    end else if (page_reg == `PAGE_00 && ptr_reg[6:0] == 7'h00) begin
      rd_data = VENDOR_ID;
    end
  end

  // serial slave: bits taken on scl rise, driven after scl fall
  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    sh_next  = sh_reg;
    ptr_next = ptr_reg;
    oe_next  = oe_reg;
    rw_next  = rw_reg;
    ack_next = ack_reg;
    wr_en    = 1'b0;
    do_load  = 1'b0;
    rd_clear = 8'h00;
    if (pin_reg.sel_n) begin
      st_next = sideband_pkg::ST_IDLE;
      oe_next = 1'b0;
    end else if (start) begin
      st_next  = sideband_pkg::ST_ADDR;
      cnt_next = 4'h0;
      oe_next  = 1'b0;
    end else if (stop) begin
      st_next = sideband_pkg::ST_IDLE;
      oe_next = 1'b0;
    end else begin
      unique case (st_reg)
        sideband_pkg::ST_IDLE: begin
        end
        sideband_pkg::ST_ADDR, sideband_pkg::ST_OFFS, sideband_pkg::ST_WDATA: begin
          if (scl_rise) begin
            sh_next  = {sh_reg[6:0], pin_reg.sda};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            cnt_next = 4'h0;
            oe_next  = 1'b1;
            if (st_reg == sideband_pkg::ST_ADDR) begin
              rw_next = sh_reg[0];
              st_next = sideband_pkg::ST_ADDR_ACK;
              if (sh_reg[7:1] != DEV_ADDR) begin
                oe_next = 1'b0;
                st_next = sideband_pkg::ST_IDLE;
              end
            end else if (st_reg == sideband_pkg::ST_OFFS) begin
              ptr_next = sh_reg;
              st_next  = sideband_pkg::ST_OFFS_ACK;
            end else begin
              wr_en    = 1'b1;
              ptr_next = ptr_reg + 8'h01;
              st_next  = sideband_pkg::ST_WDATA_ACK;
            end
          end
        end
        sideband_pkg::ST_ADDR_ACK, sideband_pkg::ST_OFFS_ACK, sideband_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            oe_next = 1'b0;
            if (st_reg == sideband_pkg::ST_ADDR_ACK && rw_reg) begin
              do_load = 1'b1;
            end else if (st_reg == sideband_pkg::ST_ADDR_ACK) begin
              st_next = sideband_pkg::ST_OFFS;
            end else begin
              st_next = sideband_pkg::ST_WDATA;
            end
          end
        end
        sideband_pkg::ST_RDATA: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            cnt_next = 4'h0;
            oe_next  = 1'b0;
            st_next  = sideband_pkg::ST_RACK;
          end else if (scl_fall) begin
            sh_next = {sh_reg[6:0], 1'b0};
            oe_next = ~sh_reg[6];
          end
        end
        sideband_pkg::ST_RACK: begin
          if (scl_rise) begin
            ack_next = ~pin_reg.sda;
          end else if (scl_fall && ack_reg) begin
            do_load = 1'b1;
          end else if (scl_fall) begin
            st_next = sideband_pkg::ST_IDLE;
          end
        end
        default: st_next = sideband_pkg::ST_IDLE;
      endcase
    end
    // a byte handed out for reading clears the flags it carried
    if (do_load) begin
      sh_next  = rd_data;
      oe_next  = ~rd_data[7];
      ptr_next = ptr_reg + 8'h01;
      cnt_next = 4'h0;
      st_next  = sideband_pkg::ST_RDATA;
      rd_clear = (ptr_reg == `OFF_FLAGS) ? flags_reg : 8'h00;
    end
  end

  // lower page control bytes; other lower bytes are read only
  always_comb begin
    ctrl_next = ctrl_reg;
    page_next = page_reg;
    bank_next = bank_reg;
    if (wr_en && ptr_reg == `OFF_CTRL) ctrl_next = sh_reg;
    if (wr_en && ptr_reg == `OFF_PAGE) page_next = sh_reg;
    if (wr_en && ptr_reg == `OFF_BANK) bank_next = sh_reg;
  end

  always_ff @(posedge clk) begin
    if (lr) begin
      st_reg   <= sideband_pkg::ST_IDLE;
      cnt_reg  <= 4'h0;
      sh_reg   <= `RST_BYTE;
      ptr_reg  <= `RST_BYTE;
      oe_reg   <= 1'b0;
      rw_reg   <= 1'b0;
      ack_reg  <= 1'b0;
      ctrl_reg <= `RST_BYTE;
      page_reg <= `RST_BYTE;
      bank_reg <= `RST_BYTE;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      sh_reg   <= sh_next;
      ptr_reg  <= ptr_next;
      oe_reg   <= oe_next;
      rw_reg   <= rw_next;
      ack_reg  <= ack_next;
      ctrl_reg <= ctrl_next;
      page_reg <= page_next;
      bank_reg <= bank_next;
    end
  end

  // writable upper pages; pages 00 to 02 take no writes
  always_ff @(posedge clk) begin
    if (lr) begin
      for (int i = 0; i < 384; i++) mem[i] <= `RST_BYTE;
    end else if (wr_en && map_hit) begin
      mem[map_idx] <= sh_reg;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sel_quiet_a: assert property (pin_reg.sel_n |=> !sda_oe)
    else $error("bus driven while deselected");
  addr_ack_a: assert property (st_reg == sideband_pkg::ST_ADDR && scl_fall && cnt_reg == 4'h8
    && sh_reg[7:1] == DEV_ADDR && !pin_reg.sel_n && !start && !stop && !lr
    |=> sda_oe)
    else $error("own address not acknowledged");
  reset_defaults_a: assert property (hold |=> page_reg == 8'h00 && ctrl_reg == 8'h00
    && !high_power_mode && interrupt_n)
    else $error("settings survive long reset");
  low_power_a: assert property (pin_reg.init && !ctrl_reg[`CTRL_HP_BIT] && !lr
    |=> !high_power_mode)
    else $error("high power without software enable");
  hw_power_a: assert property (mgmt_ready && !pin_reg.init && !lr |=> high_power_mode)
    else $error("hardware mode did not enter high power");
  present_low_a: assert property (module_present_n == 1'b0)
    else $error("presence not asserted");
  int_set_a: assert property (|flag_event && !lr |=> !interrupt_n)
    else $error("event did not assert interrupt");
  int_hold_a: assert property (flags_reg != 8'h00 && rd_clear == 8'h00 && !lr
    |=> !interrupt_n)
    else $error("interrupt released with unread flags");
  user_write_a: assert property (wr_en && map_hit && !lr
    |=> mem[$past(map_idx)] == $past(sh_reg))
    else $error("upper page write lost");
  lower_map_a: assert property (!ptr_reg[7] |-> !map_hit)
    else $error("lower half mapped to upper page");
  reserved_zero_a: assert property (ptr_reg[7] && !map_hit && page_reg != `PAGE_00
    |-> rd_data == 8'h00)
    else $error("unused byte reads nonzero");
endmodule
`default_nettype wire

// *** sim/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model #(
  parameter int Q = 5
) (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  // bus idles released; the line has a pull-up, so 1 means let go
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data moves mid-low; sampled late in high so the slave's filter has settled
  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    tick(Q);
    scl <= 1'b1;
    tick(2 * Q);
    @(negedge clk) r = sda_line;
    tick(1);
    scl <= 1'b0;
    tick(Q);
  endtask
  task automatic start();
    sda_drv <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(2 * Q);
    sda_drv <= 1'b0;
    tick(2 * Q);
    scl <= 1'b0;
    tick(Q);
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(2 * Q);
    sda_drv <= 1'b1;
    tick(2 * Q);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // a single byte per read, closed by a nack
  task automatic recv(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
  endtask
  // flags and data are only ever learnt by reading over the bus
  task automatic rd(input logic [6:0] dev, input logic [7:0] off, output logic [7:0] d,
                    output logic ack);
    logic a, b, c;
    start();
    send({dev, 1'b0}, a);
    send(off, b);
    start();
    send({dev, 1'b1}, c);
    recv(d);
    stop();
    ack = a & b & c;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] off, input logic [7:0] d,
                    output logic ack);
    logic a, b, c;
    start();
    send({dev, 1'b0}, a);
    send(off, b);
    send(d, c);
    stop();
    ack = a & b & c;
  endtask
endmodule
`default_nettype wire

// *** sim/test_module_sideband_and_paged_map.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_module_sideband_and_paged_map;
  localparam logic [6:0] DEV      = 7'h50;
  localparam logic [7:0] VID      = 8'h5A; // arbitrary value
  localparam int         RST_CYC  = 20;
  localparam int         INIT_CYC = 4;
  logic       clk    = 1'b0;
  logic       rst    = 1'b1;
  logic       sel_n  = 1'b0;
  logic       mrst_n = 1'b1;
  logic       init   = 1'b0;
  logic [7:0] ev     = 8'h00;
  logic       scl, sda_drv, sda_oe, sda_out, irq_n, prs_n, hp, ready, ack;
  logic [7:0] d;
  logic [7:0] mem [int];
  int         fail_count = 0;
  int         num_checks = 0;
  int         seed = 27933;
  int         page, bank, flags, v;
  int         pg [5] = '{0, 1, 2, 16, 17};
  wire logic  sda = sda_oe ? sda_out : sda_drv; // pull-up when nobody pulls low
  always #2.5 clk = ~clk;
  module_sideband_and_paged_map #(
    .DEV_ADDR(DEV), .VENDOR_ID(VID), .RESET_CYCLES(RST_CYC), .INIT_CYCLES(INIT_CYC)
  ) u_module_sideband_and_paged_map (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .module_select_n(sel_n), .module_reset_n(mrst_n), .init_control_select(init),
    .flag_event(ev), .interrupt_n(irq_n), .module_present_n(prs_n),
    .high_power_mode(hp), .mgmt_ready(ready)
  );
  host_model u_host_model (.clk(clk), .sda_line(sda), .scl(scl), .sda_drv(sda_drv));
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  // reference map: only page 03 and bank 0 pages 10h/11h keep written bytes
  function automatic logic [7:0] expect_byte(input int off);
    if (off == 'h7F) return 8'(page);
    if (off == 'h7E) return 8'(bank);
    if (off == 8) return 8'(flags);
    if (off < 128) return 8'h00;
    return mem.exists(bank * 65536 + page * 256 + off) ? mem[bank * 65536 + page * 256 + off]
                                                       : 8'h00;
  endfunction
  task automatic model_clear(input int f);
    mem.delete();
    mem[128] = VID;
    page = 0;
    bank = 0;
    flags = f;
  endtask
  task automatic put(input int off, input int x, input logic ea);
    u_host_model.wr(DEV, 8'(off), 8'(x), ack);
    chk1(ack, ea);
    if (!ea) return;
    if (off == 'h7F) page = x;
    if (off == 'h7E) bank = x;
    if (off >= 128 && (page == 3 || (bank == 0 && (page == 16 || page == 17))))
      mem[bank * 65536 + page * 256 + off] = 8'(x);
  endtask
  task automatic get(input int off);
    u_host_model.rd(DEV, 8'(off), d, ack);
    chk1(ack, 1'b1);
    chk8(d, expect_byte(off));
    if (off == 8) flags = 0; // reading the flag byte clears what was read
  endtask
  // the host leaves settle time after every select change
  task automatic sel(input logic x);
    @(posedge clk);
    sel_n <= x;
    repeat (10) @(posedge clk);
  endtask
  task automatic pulse_reset(input int n);
    @(posedge clk);
    mrst_n <= 1'b0;
    repeat (n) @(posedge clk);
    mrst_n <= 1'b1;
    repeat (INIT_CYC + 20) @(posedge clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    model_clear(1); // hardware-controlled wake-up flips power mode, flag bit 0
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (INIT_CYC + 10) @(posedge clk);
    chk1(prs_n, 1'b0);
    chk1(hp, 1'b1);
    chk1(ready, 1'b1);
    chk1(irq_n, 1'b0);
    get(8);
    chk1(irq_n, 1'b1);
    v = ($random(seed) & 255) | 2;
    @(posedge clk);
    ev <= 8'(v);
    @(posedge clk);
    ev <= 8'h00;
    flags = v;
    repeat (4) @(posedge clk);
    chk1(irq_n, 1'b0);
    get(8);
    chk1(irq_n, 1'b1);
    $display("test flags done");
    put('h7F, 3, 1'b1);
    for (int i = 0; i < 4; i++) put('h80 + i * 31, $random(seed) & 255, 1'b1);
    for (int i = 0; i < 4; i++) get('h80 + i * 31);
    foreach (pg[i]) begin
      put('h7F, pg[i], 1'b1);
      put('hA0, $random(seed) & 255, 1'b1);
      get('hA0);
      get('h80);
    end
    put('h7E, 1, 1'b1);
    get('hA0);
    put('h7E, 0, 1'b1);
    get('hA0);
    put('h10, $random(seed) & 255, 1'b1);
    get('h10);
    $display("test paging done");
    sel(1'b1);
    put('h7F, 5, 1'b0);
    sel(1'b0);
    get('h7F);
    u_host_model.wr(DEV ^ 7'h01, 8'h7F, 8'h06, ack);
    chk1(ack, 1'b0);
    get('h7F);
    $display("test select done");
    put('h7F, 3, 1'b1);
    pulse_reset(RST_CYC / 2);
    get('h80);
    pulse_reset(RST_CYC + 10);
    model_clear(1);
    get('h7F);
    put('h7F, 3, 1'b1);
    get('h80);
    get(8);
    $display("test reset done");
    @(posedge clk);
    rst <= 1'b1;
    init <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (INIT_CYC + 10) @(posedge clk);
    model_clear(0);
    chk1(hp, 1'b0);
    chk1(irq_n, 1'b1);
    put('h1A, 'h10, 1'b1);
    flags = 1;
    repeat (4) @(posedge clk);
    chk1(hp, 1'b1);
    get(8);
    $display("test init done");
    final_report();
  end
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
